// ### hdl/lcdh_device.sv
// Display controller end: host port, reset, frame divider, supply and bias control
// Behaviour
// - Two 8-bit registers chosen by register_select
// - Instruction register writable, never read back
// - Data reads copy RAM byte into holding first
// - Synchronous power-on reset lasting three cycles
// - Frame tick every 3072 clock cycles
// - Host stops clock only in power-down
// - Two 6-bit supply code registers
// - Zero code turns generator off; mode picks
// - Voltage is code times 0.08 plus 1.82
// - Host keeps codes within 2.2 to 6.5
// - Direct mode bypasses generator to second rail
// - Bias levels follow multiplex rate automatically
// - Strobe held low during serial bus use
// - Four-bit transfers use lines 7 to 4
// - Line 7 carries busy indication
// - Line 3 doubles as slave address bit
// - Instructions refused while busy
// - Status read gives busy and address counter
`timescale 1ns/1ps
module lcdh_device #(
	parameter int BUSY_CYCLES = lcdh_pkg::DEV_BUSY_CYC,
	parameter int FRAME_DIV = lcdh_pkg::FRAME_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	lcdh_link_if.dev link,
	input wire logic four_bit_mode,
	input wire logic serial_mode,
	input wire logic core_busy,
	input wire logic [lcdh_pkg::ADDR_W-1:0] addr_counter,
	output logic instr_valid,
	output logic [lcdh_pkg::BYTE_W-1:0] instr_code,
	output logic instr_refused,
	output logic data_wr_valid,
	output logic [lcdh_pkg::BYTE_W-1:0] data_wr,
	output logic ram_rd_req,
	input wire logic ram_rd_valid,
	input wire logic [lcdh_pkg::BYTE_W-1:0] ram_rd_data,
	output logic slave_address_bit,
	output logic core_ready,
	output logic frame_tick,
	input wire logic char_code_wr,
	input wire logic icon_code_wr,
	input wire logic [lcdh_pkg::VCODE_W-1:0] code_wdata,
	input wire logic icon_mode,
	input wire logic direct_supply_mode,
	input wire lcdh_pkg::lcdh_mux_e mux_rate,
	output logic supply_gen_on,
	output logic supply_from_rail2,
	output logic [lcdh_pkg::VCODE_W-1:0] supply_code,
	output logic [lcdh_pkg::MV_W-1:0] supply_mv,
	output logic bias_five_level
);
	localparam int SYNC_W = lcdh_pkg::BYTE_W + 4;
	localparam int BUSY_W = $clog2(BUSY_CYCLES + 1);
	localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_CYCLES);
	localparam logic [1:0] POR_DONE = 2'(lcdh_pkg::POR_CYCLES);
	localparam logic [lcdh_pkg::FRAME_CNT_W-1:0] FRAME_LAST = lcdh_pkg::FRAME_CNT_W'(FRAME_DIV - 1);

	generate
		if (BUSY_CYCLES < 1 || FRAME_DIV < 2 || FRAME_DIV > 4096) begin : g_bad_param
			$error("lcdh_device: parameter out of range");
		end
	endgenerate

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic stb_d_r;
	logic [lcdh_pkg::BYTE_W-1:0] lat_line_r;
	logic lat_rs_r;
	logic lat_rw_r;
	logic nib_r;
	logic [lcdh_pkg::NIB_W-1:0] hi_nib_r;
	logic [BUSY_W-1:0] busy_cnt_r;
	logic [lcdh_pkg::BYTE_W-1:0] holding_r;
	logic holding_valid_r;
	logic [1:0] por_cnt_r;
	logic [lcdh_pkg::FRAME_CNT_W-1:0] frame_cnt_r;
	logic [lcdh_pkg::VCODE_W-1:0] char_code_r;
	logic [lcdh_pkg::VCODE_W-1:0] icon_code_r;
	logic [lcdh_pkg::BYTE_W-1:0] dev_data_r;
	logic [lcdh_pkg::BYTE_W-1:0] dev_oe_r;

	// Pin inputs pass two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {link.bus_strobe, link.register_select, link.read_write_select,
				link.power_down_select, link.bus_line};
			sync2_r <= sync1_r;
		end
	end

	wire stb = sync2_r[SYNC_W-1];
	wire rs_s = sync2_r[SYNC_W-2];
	wire rw_s = sync2_r[SYNC_W-3];
	wire pd_s = sync2_r[SYNC_W-4];
	wire [lcdh_pkg::BYTE_W-1:0] line_s = sync2_r[lcdh_pkg::BYTE_W-1:0];
	wire run = core_ready && !serial_mode;
	wire stb_rise = run && stb && !stb_d_r;
	wire stb_fall = run && !stb && stb_d_r;
	wire busy = (busy_cnt_r != '0) || core_busy;
	wire last_nib = !four_bit_mode || nib_r;
	wire [lcdh_pkg::BYTE_W-1:0] full_byte = four_bit_mode ? {hi_nib_r, lat_line_r[7:4]} : lat_line_r;
	wire wr_done = stb_fall && !lat_rw_r && last_nib;
	wire instr_take = wr_done && !lat_rs_r && !busy;
	wire rd_start = stb_rise && rw_s && rs_s && !(four_bit_mode && nib_r);
	wire [lcdh_pkg::BYTE_W-1:0] status_byte = {busy, addr_counter};
	wire [lcdh_pkg::BYTE_W-1:0] rd_byte = rs_s ? holding_r : status_byte;
	wire [lcdh_pkg::BYTE_W-1:0] rd_lane = (four_bit_mode && nib_r) ? {rd_byte[3:0], 4'h0} : rd_byte;
	wire rd_ready = !rs_s || holding_valid_r;
	wire drive = run && stb && rw_s && rd_ready;
	wire [lcdh_pkg::BYTE_W-1:0] oe_nxt = drive ? (four_bit_mode ? lcdh_pkg::OE_UPPER : lcdh_pkg::OE_FULL) : '0;
	wire [lcdh_pkg::VCODE_W-1:0] sel_code = icon_mode ? icon_code_r : char_code_r;
	wire [lcdh_pkg::MV_W-1:0] mv_nxt = lcdh_pkg::MV_W'(sel_code) * lcdh_pkg::VSTEP_MV + lcdh_pkg::VOFFSET_MV;

	assign link.dev_data = dev_data_r;
	assign link.dev_data_oe = dev_oe_r;

	// Synchronous power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_cnt_r <= 2'b00;
			core_ready <= 1'b0;
		end else begin
			if (por_cnt_r != POR_DONE) begin
				por_cnt_r <= por_cnt_r + 2'b01;
			end
			core_ready <= (por_cnt_r == POR_DONE);
		end
	end

	// Strobe tracking and write latching
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stb_d_r <= 1'b0;
			lat_line_r <= lcdh_pkg::BYTE_RST;
			lat_rs_r <= 1'b0;
			lat_rw_r <= 1'b0;
			nib_r <= 1'b0;
			hi_nib_r <= 4'h0;
		end else if (!core_ready) begin
			stb_d_r <= 1'b0;
			nib_r <= 1'b0;
		end else begin
			stb_d_r <= stb;
			if (stb) begin
				lat_line_r <= line_s;
				lat_rs_r <= rs_s;
				lat_rw_r <= rw_s;
			end
			if (!four_bit_mode) begin
				nib_r <= 1'b0;
			end else if (stb_fall) begin
				nib_r <= !nib_r;
				if (!nib_r) begin
					hi_nib_r <= lat_line_r[7:4];
				end
			end
		end
	end

	// Instruction and data hand-off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_valid <= 1'b0;
			instr_code <= lcdh_pkg::BYTE_RST;
			instr_refused <= 1'b0;
			data_wr_valid <= 1'b0;
			data_wr <= lcdh_pkg::BYTE_RST;
			busy_cnt_r <= '0;
		end else begin
			instr_valid <= instr_take;
			instr_refused <= wr_done && !lat_rs_r && busy;
			data_wr_valid <= wr_done && lat_rs_r;
			if (instr_take) begin
				instr_code <= full_byte;
			end
			if (wr_done && lat_rs_r) begin
				data_wr <= full_byte;
			end
			if (!core_ready) begin
				busy_cnt_r <= '0;
			end else if (instr_take) begin
				busy_cnt_r <= BUSY_LOAD;
			end else if (busy_cnt_r != '0) begin
				busy_cnt_r <= busy_cnt_r - 1'b1;
			end
		end
	end

	// Holding register fetch and read drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_rd_req <= 1'b0;
			holding_r <= lcdh_pkg::BYTE_RST;
			holding_valid_r <= 1'b0;
			dev_data_r <= lcdh_pkg::BYTE_RST;
			dev_oe_r <= '0;
			slave_address_bit <= 1'b0;
		end else begin
			ram_rd_req <= rd_start;
			if (rd_start) begin
				holding_valid_r <= 1'b0;
			end else if (ram_rd_valid) begin
				holding_r <= ram_rd_data;
				holding_valid_r <= 1'b1;
			end
			dev_data_r <= rd_lane;
			dev_oe_r <= oe_nxt;
			if (serial_mode) begin
				slave_address_bit <= line_s[lcdh_pkg::SADDR_BIT];
			end
		end
	end

	// Frame divider, held while powered down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt_r <= '0;
			frame_tick <= 1'b0;
		end else if (!core_ready || pd_s) begin
			frame_tick <= 1'b0;
		end else begin
			frame_tick <= (frame_cnt_r == FRAME_LAST);
			frame_cnt_r <= (frame_cnt_r == FRAME_LAST) ? '0 : frame_cnt_r + 1'b1;
		end
	end

	// Supply code registers and supply control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			char_code_r <= lcdh_pkg::VCODE_RST;
			icon_code_r <= lcdh_pkg::VCODE_RST;
			supply_gen_on <= 1'b0;
			supply_from_rail2 <= 1'b0;
			supply_code <= lcdh_pkg::VCODE_RST;
			supply_mv <= '0;
			bias_five_level <= 1'b1;
		end else if (!core_ready) begin
			char_code_r <= lcdh_pkg::VCODE_RST;
			icon_code_r <= lcdh_pkg::VCODE_RST;
		end else begin
			if (char_code_wr) begin
				char_code_r <= code_wdata;
			end
			if (icon_code_wr) begin
				icon_code_r <= code_wdata;
			end
			supply_code <= sel_code;
			supply_gen_on <= (sel_code != lcdh_pkg::VCODE_OFF) && !direct_supply_mode;
			supply_from_rail2 <= direct_supply_mode;
			supply_mv <= mv_nxt;
			bias_five_level <= (mux_rate != lcdh_pkg::LCDH_MUX_1_2);
		end
	end
endmodule

// ### pkg/lcdh_pkg.sv
// Shared constants and types for the display controller host port
package lcdh_pkg;
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 7;
	localparam int VCODE_W = 6;
	localparam int MV_W = 13;
	localparam logic [VCODE_W-1:0] VCODE_RST = 6'h00;
	localparam logic [VCODE_W-1:0] VCODE_OFF = 6'h00;
	localparam logic [MV_W-1:0] VSTEP_MV = 13'h0050;
	localparam logic [MV_W-1:0] VOFFSET_MV = 13'h071C;
	localparam int POR_CYCLES = 3;
	localparam int FRAME_DIV = 3072;
	localparam int FRAME_CNT_W = 12;
	localparam int DEV_BUSY_CYC = 8;
	localparam int HOST_SETUP_CYC = 2;
	localparam int HOST_STROBE_CYC = 12;
	localparam int HOST_HOLD_CYC = 4;
	localparam int BUSY_BIT = 7;
	localparam int SADDR_BIT = 3;
	localparam logic [BYTE_W-1:0] OE_FULL = 8'hFF;
	localparam logic [BYTE_W-1:0] OE_UPPER = 8'hF0;
	localparam logic [BYTE_W-1:0] OE_SADDR = 8'h08;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CMD = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_RDATA = 4'hC;
	localparam int CTRL_FOUR_BIT = 0;
	localparam int CTRL_SERIAL = 1;
	localparam int CTRL_PDOWN = 2;
	localparam int CTRL_SADDR = 3;
	localparam int CMD_RS = 8;
	localparam int CMD_RW = 9;
	localparam int STAT_ACTIVE = 0;
	localparam int STAT_DEV_BUSY = 1;
	typedef enum logic [1:0] {LCDH_MUX_1_18, LCDH_MUX_1_9, LCDH_MUX_1_2} lcdh_mux_e;
endpackage

// ### pkg/lcdh_link_if.sv
// Parallel link between host controller and display controller
`timescale 1ns/1ps
interface lcdh_link_if;
	logic bus_strobe;
	logic register_select;
	logic read_write_select;
	logic power_down_select;
	logic [7:0] host_data;
	logic [7:0] host_data_oe;
	logic [7:0] dev_data;
	logic [7:0] dev_data_oe;
	logic [7:0] bus_line;
	// Undriven lines float high
	assign bus_line = (dev_data & dev_data_oe) | (host_data & host_data_oe & ~dev_data_oe) |
		~(dev_data_oe | host_data_oe);
	modport dev (input bus_strobe, input register_select, input read_write_select,
		input power_down_select, input bus_line, output dev_data, output dev_data_oe);
	modport host (output bus_strobe, output register_select, output read_write_select,
		output power_down_select, output host_data, output host_data_oe, input bus_line);
endinterface

// ### hdl/lcdh_host.sv
// Host end: APB-controlled driver of the parallel display link
`timescale 1ns/1ps
module lcdh_host #(
	parameter int SETUP_CYC = lcdh_pkg::HOST_SETUP_CYC,
	parameter int STROBE_CYC = lcdh_pkg::HOST_STROBE_CYC,
	parameter int HOLD_CYC = lcdh_pkg::HOST_HOLD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	lcdh_link_if.host link
);
	typedef enum {H_IDLE, H_SETUP, H_HIGH, H_HOLD} lcdh_hstate_e;
	localparam int TMR_W = 8;

	generate
		if (SETUP_CYC < 1 || STROBE_CYC < 6 || HOLD_CYC < 1 || STROBE_CYC > 255 || SETUP_CYC > 256 ||
			HOLD_CYC > 256) begin : g_bad_param
			$error("lcdh_host: timing parameter out of range");
		end
	endgenerate

	lcdh_hstate_e st_r;
	logic [3:0] ctrl_r;
	logic [lcdh_pkg::BYTE_W-1:0] wbyte_r;
	logic rs_r;
	logic rw_r;
	logic polling_r;
	logic nib_r;
	logic [TMR_W-1:0] tmr_r;
	logic [lcdh_pkg::BYTE_W-1:0] rbyte_r;
	logic [lcdh_pkg::BYTE_W-1:0] rdata_r;
	logic dev_busy_r;
	logic [lcdh_pkg::BYTE_W-1:0] sync1_r;
	logic [lcdh_pkg::BYTE_W-1:0] sync2_r;
	logic strobe_r;
	logic [lcdh_pkg::BYTE_W-1:0] hdata_r;
	logic [lcdh_pkg::BYTE_W-1:0] hoe_r;

	wire four_bit = ctrl_r[lcdh_pkg::CTRL_FOUR_BIT];
	wire serial = ctrl_r[lcdh_pkg::CTRL_SERIAL];
	wire acc = psel && penable;
	wire [3:0] ofs = paddr[3:0];
	wire hit_ctrl = ofs == lcdh_pkg::OFS_CTRL;
	wire hit_cmd = ofs == lcdh_pkg::OFS_CMD;
	wire hit_stat = ofs == lcdh_pkg::OFS_STATUS;
	wire hit_rdat = ofs == lcdh_pkg::OFS_RDATA;
	wire mapped = (paddr[31:4] == '0) && (hit_ctrl || hit_cmd || hit_stat || hit_rdat);
	wire start = acc && pwrite && mapped && hit_cmd && st_r == H_IDLE && !serial;
	wire tmr_end = tmr_r == '0;
	wire cur_rs = polling_r ? 1'b0 : rs_r;
	wire cur_rw = polling_r ? 1'b1 : rw_r;
	wire [lcdh_pkg::BYTE_W-1:0] rbyte_nxt = !four_bit ? sync2_r :
		(nib_r ? {rbyte_r[7:4], sync2_r[7:4]} : {sync2_r[7:4], rbyte_r[3:0]});
	wire [lcdh_pkg::BYTE_W-1:0] wlane = four_bit ? (nib_r ? {wbyte_r[3:0], 4'h0} : {wbyte_r[7:4], 4'h0}) : wbyte_r;
	wire [lcdh_pkg::BYTE_W-1:0] woe = four_bit ? lcdh_pkg::OE_UPPER : lcdh_pkg::OE_FULL;
	wire last_nib = !four_bit || nib_r;
	wire [31:0] stat_word = {30'h0000_0000, dev_busy_r, st_r != H_IDLE};

	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata = !(psel && !pwrite && mapped) ? 32'h0000_0000 :
		hit_ctrl ? {28'h000_0000, ctrl_r} :
		hit_stat ? stat_word :
		hit_rdat ? {24'h00_0000, rdata_r} : 32'h0000_0000;
	assign link.bus_strobe = strobe_r;
	assign link.register_select = cur_rs;
	assign link.read_write_select = cur_rw;
	assign link.power_down_select = ctrl_r[lcdh_pkg::CTRL_PDOWN];
	assign link.host_data = hdata_r;
	assign link.host_data_oe = hoe_r;

	// Bus lines from the device pass two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= link.bus_line;
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 4'h0;
			wbyte_r <= lcdh_pkg::BYTE_RST;
			rs_r <= 1'b0;
			rw_r <= 1'b0;
		end else if (acc && pwrite) begin
			if (hit_ctrl && st_r == H_IDLE) begin
				ctrl_r <= pwdata[3:0];
			end
			if (start) begin
				wbyte_r <= pwdata[7:0];
				rs_r <= pwdata[lcdh_pkg::CMD_RS];
				rw_r <= pwdata[lcdh_pkg::CMD_RW];
			end
		end
	end

	// Transfer sequencer: setup, strobe high, hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= H_IDLE;
			polling_r <= 1'b0;
			nib_r <= 1'b0;
			tmr_r <= '0;
			rbyte_r <= lcdh_pkg::BYTE_RST;
			rdata_r <= lcdh_pkg::BYTE_RST;
			dev_busy_r <= 1'b0;
			strobe_r <= 1'b0;
		end else begin
			case (st_r)
				H_IDLE: begin
					strobe_r <= 1'b0;
					nib_r <= 1'b0;
					if (start) begin
						polling_r <= !pwdata[lcdh_pkg::CMD_RS] && !pwdata[lcdh_pkg::CMD_RW];
						tmr_r <= TMR_W'(SETUP_CYC - 1);
						st_r <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (tmr_end) begin
						strobe_r <= 1'b1;
						tmr_r <= TMR_W'(STROBE_CYC - 1);
						st_r <= H_HIGH;
					end else begin
						tmr_r <= tmr_r - 1'b1;
					end
				end
				H_HIGH: begin
					if (tmr_end) begin
						strobe_r <= 1'b0;
						if (cur_rw) begin
							rbyte_r <= rbyte_nxt;
						end
						tmr_r <= TMR_W'(HOLD_CYC - 1);
						st_r <= H_HOLD;
					end else begin
						tmr_r <= tmr_r - 1'b1;
					end
				end
				H_HOLD: begin
					if (!tmr_end) begin
						tmr_r <= tmr_r - 1'b1;
					end else begin
						tmr_r <= TMR_W'(SETUP_CYC - 1);
						if (!last_nib) begin
							nib_r <= 1'b1;
							st_r <= H_SETUP;
						end else begin
							nib_r <= 1'b0;
							if (polling_r) begin
								dev_busy_r <= rbyte_r[lcdh_pkg::BUSY_BIT];
								polling_r <= rbyte_r[lcdh_pkg::BUSY_BIT];
								st_r <= H_SETUP;
							end else begin
								if (rw_r) begin
									rdata_r <= rbyte_r;
								end
								st_r <= H_IDLE;
							end
						end
					end
				end
				default: begin
					st_r <= H_IDLE;
				end
			endcase
		end
	end

	// Line drive: write data on the bus, or slave address in serial mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdata_r <= lcdh_pkg::BYTE_RST;
			hoe_r <= '0;
		end else if (serial) begin
			hdata_r <= {4'h0, ctrl_r[lcdh_pkg::CTRL_SADDR], 3'h0};
			hoe_r <= lcdh_pkg::OE_SADDR;
		end else if (st_r != H_IDLE && !cur_rw) begin
			hdata_r <= wlane;
			hoe_r <= woe;
		end else begin
			hdata_r <= lcdh_pkg::BYTE_RST;
			hoe_r <= '0;
		end
	end
endmodule

// ### tb/lcdh_assertions.sv
// Checker for the display link and device core outputs
`timescale 1ns/1ps
module lcdh_assertions #(
	parameter int FRAME_DIV = lcdh_pkg::FRAME_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bus_strobe,
	input wire logic register_select,
	input wire logic read_write_select,
	input wire logic power_down_select,
	input wire logic [7:0] host_data_oe,
	input wire logic [7:0] dev_data_oe,
	input wire logic four_bit_mode,
	input wire logic serial_mode,
	input wire logic frame_tick,
	input wire logic core_ready,
	input wire logic supply_gen_on,
	input wire logic supply_from_rail2,
	input wire logic [5:0] supply_code,
	input wire logic [12:0] supply_mv,
	input wire logic bias_five_level,
	input wire lcdh_pkg::lcdh_mux_e mux_rate
);
	localparam int LAST = FRAME_DIV - 1;
	logic [15:0] cnt_r;
	logic seen_r;
	// Cycles since the last frame tick, restarted by power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			seen_r <= 1'b0;
		end else if (power_down_select) begin
			cnt_r <= 16'h0000;
			seen_r <= 1'b0;
		end else if (frame_tick) begin
			cnt_r <= 16'h0000;
			seen_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_ready_wait;
		!core_ready ##1 !core_ready ##[1:3] core_ready;
	endsequence
	sequence s_mux_held;
		$stable(mux_rate) [*3];
	endsequence
	property p_ready_after_reset;
		$rose(presetn) |-> s_ready_wait;
	endproperty
	property p_frame_period;
		frame_tick && seen_r |-> cnt_r == 16'(LAST);
	endproperty
	property p_frame_bound;
		seen_r |-> cnt_r <= 16'(LAST);
	endproperty
	property p_supply_mv;
		supply_gen_on |-> supply_mv == {7'h00, supply_code} * 13'h0050 + 13'h071C;
	endproperty
	property p_gen_off;
		supply_gen_on |-> supply_code != 6'h00 && !supply_from_rail2;
	endproperty
	property p_bias;
		s_mux_held |-> bias_five_level == (mux_rate != lcdh_pkg::LCDH_MUX_1_2);
	endproperty
	property p_strobe_stable;
		bus_strobe && $past(bus_strobe) |-> $stable(register_select) && $stable(read_write_select);
	endproperty
	property p_drive_on_read;
		$rose(dev_data_oe != 8'h00) |-> read_write_select && bus_strobe;
	endproperty
	property p_four_bit_lines;
		four_bit_mode |-> dev_data_oe[3:0] == 4'h0 && host_data_oe[3:0] == 4'h0;
	endproperty
	property p_serial_quiet;
		serial_mode |-> !bus_strobe;
	endproperty
	a_ready_after_reset: assert property (p_ready_after_reset) else $error("core_ready timing wrong");
	a_frame_period: assert property (p_frame_period) else $error("frame tick spacing wrong");
	a_frame_bound: assert property (p_frame_bound) else $error("frame tick missing");
	a_supply_mv: assert property (p_supply_mv) else $error("supply voltage wrong");
	a_gen_off: assert property (p_gen_off) else $error("generator on with zero code");
	a_bias: assert property (p_bias) else $error("bias level count wrong");
	a_strobe_stable: assert property (p_strobe_stable) else $error("select moved in strobe");
	a_drive_on_read: assert property (p_drive_on_read) else $error("device drove on a write");
	a_four_bit_lines: assert property (p_four_bit_lines) else $error("low lines driven");
	a_serial_quiet: assert property (p_serial_quiet) else $error("strobe in serial mode");
endmodule

// ### tb/lcdh_tb.sv
// Bench joining host and device ends of the display link
`timescale 1ns/1ps
module lcdh_tb;
	localparam int FDIV = 16;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata;
	logic four_bit_mode = 1'b0, serial_mode = 1'b0, core_busy = 1'b0, icon_mode = 1'b0;
	logic direct_supply_mode = 1'b0, ram_rd_valid = 1'b0, char_code_wr = 1'b0, icon_code_wr = 1'b0;
	logic [6:0] addr_counter = 7'h35;
	logic [7:0] ram_rd_data = 8'h3C;
	logic [5:0] code_wdata = 6'h00;
	lcdh_pkg::lcdh_mux_e mux_rate = lcdh_pkg::LCDH_MUX_1_18;
	logic instr_valid, instr_refused, data_wr_valid, ram_rd_req, slave_address_bit, core_ready;
	logic frame_tick, supply_gen_on, supply_from_rail2, bias_five_level;
	logic [7:0] instr_code, data_wr;
	logic [7:0] last_ins = 8'h00, last_dat = 8'h00;
	logic [5:0] supply_code;
	logic [12:0] supply_mv;
	logic [31:0] r;
	logic e;
	int ins_n = 0;
	int ref_n = 0;
	int err_total = 0;
	int checks_done = 0;
	int n;
	always #2.5 pclk = ~pclk;
	lcdh_link_if i_lcdh_link_if();
	lcdh_device #(.FRAME_DIV(FDIV)) i_lcdh_device (.pclk(pclk), .presetn(presetn), .link(i_lcdh_link_if),
		.four_bit_mode(four_bit_mode), .serial_mode(serial_mode), .core_busy(core_busy),
		.addr_counter(addr_counter), .instr_valid(instr_valid), .instr_code(instr_code),
		.instr_refused(instr_refused), .data_wr_valid(data_wr_valid), .data_wr(data_wr),
		.ram_rd_req(ram_rd_req), .ram_rd_valid(ram_rd_valid), .ram_rd_data(ram_rd_data),
		.slave_address_bit(slave_address_bit), .core_ready(core_ready), .frame_tick(frame_tick),
		.char_code_wr(char_code_wr), .icon_code_wr(icon_code_wr), .code_wdata(code_wdata),
		.icon_mode(icon_mode), .direct_supply_mode(direct_supply_mode), .mux_rate(mux_rate),
		.supply_gen_on(supply_gen_on), .supply_from_rail2(supply_from_rail2), .supply_code(supply_code),
		.supply_mv(supply_mv), .bias_five_level(bias_five_level));
	lcdh_host i_lcdh_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(i_lcdh_link_if));
	lcdh_assertions #(.FRAME_DIV(FDIV)) i_lcdh_assertions (.pclk(pclk), .presetn(presetn),
		.bus_strobe(i_lcdh_link_if.bus_strobe), .register_select(i_lcdh_link_if.register_select),
		.read_write_select(i_lcdh_link_if.read_write_select), .host_data_oe(i_lcdh_link_if.host_data_oe),
		.power_down_select(i_lcdh_link_if.power_down_select),
		.dev_data_oe(i_lcdh_link_if.dev_data_oe), .four_bit_mode(four_bit_mode), .serial_mode(serial_mode),
		.frame_tick(frame_tick), .core_ready(core_ready), .supply_gen_on(supply_gen_on),
		.supply_from_rail2(supply_from_rail2), .supply_code(supply_code), .supply_mv(supply_mv),
		.bias_five_level(bias_five_level), .mux_rate(mux_rate));
	// Display RAM answers one cycle after a fetch request
	always @(posedge pclk) begin
		ram_rd_valid <= ram_rd_req;
		if (instr_valid) begin
			last_ins <= instr_code;
			ins_n <= ins_n + 1;
		end
		if (data_wr_valid) begin
			last_dat <= data_wr;
		end
		if (instr_refused) begin
			ref_n <= ref_n + 1;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [3:0] o, input logic [31:0] d);
		apb(1'b1, {28'h000_0000, o}, d);
	endtask
	task rd(input logic [3:0] o);
		apb(1'b0, {28'h000_0000, o}, 32'h0000_0000);
	endtask
	task idle();
		n = 0;
		do begin
			rd(lcdh_pkg::OFS_STATUS);
			n++;
		end while (r[0] !== 1'b0 && n < 400);
		chk(r[0], 1'b0);
	endtask
	task cmd(input logic [9:0] c);
		wr(lcdh_pkg::OFS_CMD, {22'h00_0000, c});
		idle();
	endtask
	task settle(input int k);
		n = 0;
		while (ins_n != k && n < 40) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task vset(input logic ic, input logic [5:0] c);
		@(posedge pclk);
		icon_mode <= ic;
		code_wdata <= c;
		char_code_wr <= ~ic;
		icon_code_wr <= ic;
		@(posedge pclk);
		char_code_wr <= 1'b0;
		icon_code_wr <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(supply_code, c);
		chk(supply_gen_on, c != 6'h00);
		if (c != 6'h00) chk(supply_mv, 32'(c) * 32'h0000_0050 + 32'h0000_071C);
	endtask
	task final_report();
		$display("Checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		$display("Watchdog expired");
		final_report();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		while (core_ready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk(core_ready, 1'b1);
		rd(lcdh_pkg::OFS_CTRL);
		chk(r, 32'h0000_0000);
		chk(e, 1'b0);
		apb(1'b0, 32'h0000_0010, 32'h0000_0000);
		chk(e, 1'b1);
		$display("Test registers done");
		for (int m = 0; m < 2; m++) begin
			// Status, two instructions, data read and write in 8-bit then 4-bit mode
			cmd(10'h200);
			rd(lcdh_pkg::OFS_RDATA);
			chk(r, {25'h000_0000, addr_counter});
			cmd(10'h0A5);
			cmd(10'h05A);
			settle(2 * m + 2);
			chk(last_ins, 8'h5A);
			chk(ins_n, 2 * m + 2);
			ram_rd_data <= 8'h3C ^ {8{m[0]}};
			cmd(10'h300);
			rd(lcdh_pkg::OFS_RDATA);
			chk(r, {24'h00_0000, 8'h3C ^ {8{m[0]}}});
			cmd(10'h1C7 ^ {2'b00, {8{m[0]}}});
			chk(last_dat, 8'hC7 ^ {8{m[0]}});
			wr(lcdh_pkg::OFS_CTRL, 32'h0000_0001);
			four_bit_mode <= 1'b1;
			$display("Test link pass %0d done", m);
		end
		wr(lcdh_pkg::OFS_CTRL, 32'h0000_0000);
		four_bit_mode <= 1'b0;
		core_busy <= 1'b1;
		wr(lcdh_pkg::OFS_CMD, 32'h0000_000F);
		repeat (60) @(posedge pclk);
		rd(lcdh_pkg::OFS_STATUS);
		chk(r, 32'h0000_0003);
		chk(ins_n, 4);
		core_busy <= 1'b0;
		idle();
		settle(5);
		chk(last_ins, 8'h0F);
		chk(ref_n, 0);
		$display("Test busy done");
		wr(lcdh_pkg::OFS_CTRL, 32'h0000_000A);
		serial_mode <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(slave_address_bit, 1'b1);
		wr(lcdh_pkg::OFS_CMD, 32'h0000_00AA);
		repeat (30) @(posedge pclk);
		chk(ins_n, 5);
		wr(lcdh_pkg::OFS_CTRL, 32'h0000_0002);
		repeat (6) @(posedge pclk);
		chk(slave_address_bit, 1'b0);
		serial_mode <= 1'b0;
		wr(lcdh_pkg::OFS_CTRL, 32'h0000_0000);
		$display("Test serial done");
		// Codes kept between 2.2 V and 6.5 V
		vset(1'b0, 6'h05);
		vset(1'b0, 6'h3A);
		vset(1'b0, 6'h14);
		vset(1'b1, 6'h00);
		icon_mode <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(supply_code, 6'h14);
		direct_supply_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(supply_from_rail2, 1'b1);
		chk(supply_gen_on, 1'b0);
		direct_supply_mode <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			mux_rate <= lcdh_pkg::lcdh_mux_e'(i);
			repeat (4) @(posedge pclk);
			chk(bias_five_level, lcdh_pkg::lcdh_mux_e'(i) != lcdh_pkg::LCDH_MUX_1_2);
		end
		$display("Test supply and bias done");
		// Clock may stop only in power-down: no frame ticks then
		wr(lcdh_pkg::OFS_CTRL, 32'h0000_0004);
		repeat (4) @(posedge pclk);
		n = 0;
		repeat (3 * FDIV) begin
			@(posedge pclk);
			if (frame_tick === 1'b1) n++;
		end
		chk(n, 0);
		wr(lcdh_pkg::OFS_CTRL, 32'h0000_0000);
		n = 0;
		while (frame_tick !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (frame_tick !== 1'b1 && n < 100);
		chk(n, FDIV);
		$display("Test frame done");
		final_report();
	end
endmodule
